// File: mtm_pkg.sv
// Package for the modulo timer: register map, fields, encodings and types.
package mtm_pkg;
    // Register byte addresses
    localparam logic [3:0] MTM_ADDR_SC  = 4'h0;
    localparam logic [3:0] MTM_ADDR_CLK = 4'h4;
    localparam logic [3:0] MTM_ADDR_CNT = 4'h8;
    localparam logic [3:0] MTM_ADDR_MOD = 4'hC;
    // Status/control field positions
    localparam int MTM_SC_OVF  = 7;
    localparam int MTM_SC_IEN  = 6;
    localparam int MTM_SC_RST  = 5;
    localparam int MTM_SC_HALT = 4;
    // Clock config field positions
    localparam int MTM_CLK_SRC_HI = 5;
    localparam int MTM_CLK_SRC_LO = 4;
    localparam int MTM_CLK_PS_HI  = 3;
    // Clock source encodings
    localparam logic [1:0] MTM_SRC_BUS  = 2'h0;
    localparam logic [1:0] MTM_SRC_FIX  = 2'h1;
    localparam logic [1:0] MTM_SRC_FALL = 2'h2;
    localparam logic [1:0] MTM_SRC_RISE = 2'h3;
    // Largest prescale code, divide by 256
    localparam logic [3:0] MTM_PS_MAX = 4'h8;
    // Reset values and response codes
    localparam logic [7:0] MTM_ZERO8   = 8'h00;
    localparam logic [1:0] MTM_RESP_OK = 2'h0;
    localparam logic [1:0] MTM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MTM_ST_STOPPED,
        MTM_ST_FREE,
        MTM_ST_MODULO
    } mtm_mode_e;

    // AXI4-Lite request from master
    typedef struct packed {
        logic [3:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [3:0]  araddr;
        logic        arvalid;
        logic        rready;
    } mtm_axi_req_s;

    // AXI4-Lite response to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mtm_axi_rsp_s;

    // Whole block state
    typedef struct packed {
        logic        aw_have;
        logic [3:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic        w_lane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  count;
        logic [7:0]  modulo;
        logic [1:0]  src;
        logic [3:0]  ps;
        logic        halt;
        logic        ien;
        logic        ovf;
        logic        armed;
        logic [7:0]  pre;
        logic [1:0]  pin_sync;
        logic        pin_last;
        logic [1:0]  fix_sync;
        logic        fix_last;
    } mtm_state_s;
endpackage : mtm_pkg

// File: mtm_timer.sv
// Modulo timer top: 8-bit counter, prescaler, source select, AXI4-Lite registers.
//
// Behaviour
// - Source select: 00 bus, 01 fixed clock, 10 pin falling, 11 pin rising.
// - Changing source keeps the count and continues with the new source.
// - Prescaler divides by 2 to the code, codes above 8 divide by 256.
// - Changing prescale keeps the count and continues at the new rate.
// - Count register is read-only, writes ignored, reset clears it.
// - Modulo zero counts free through full range, nonzero is compare value.
// - Any modulo write clears the count and the overflow flag (an overflow tick in the same cycle leaves the flag set).
// - Three modes: stopped, free-running, modulo.
// - Reset: stopped, count zero, modulo zero, bus clock, divide by one.
// - Count increments per tick and wraps to zero after matching modulo.
// - Overflow flag sets on the tick from modulo value to zero.
// - Flag clears by a read while set then writing zero to it.
// - An overflow between arming read and clearing write cancels the clear.
// - Writing one to counter reset bit clears the flag at once (an overflow tick in the same cycle leaves it set).
// - Interrupt request is flag and enable together.
// - Clearing the halt bit starts counting, free-running after reset.
// - Halt bit freezes count, clearing resumes, reset sets it.
// - Counter reset bit is write-only, clears count, reads zero.
// - Debug mode suspends counting, resumes from the held value.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
module mtm_timer
(
    input  wire logic                  ref_clk,        // Bus clock
    input  wire logic                  rst,            // Synchronous reset
    input  wire mtm_pkg::mtm_axi_req_s axi_req,        // AXI4-Lite request
    output mtm_pkg::mtm_axi_rsp_s      axi_rsp,        // AXI4-Lite response
    input  wire logic                  ext_timer_clock_pin, // External clock pin
    input  wire logic                  fixed_freq_clock,    // Fixed clock level
    input  wire logic                  debug_halt,     // Background debug active
    output logic                       irq,            // Overflow interrupt
    output mtm_pkg::mtm_mode_e         mode            // Counter mode
);
    import mtm_pkg::*;

    mtm_state_s s_r;
    mtm_state_s s_nxt;

    // Prescaler tap: high when the low ps bits of pre are all ones, ps capped at 8
    function automatic logic tap_hit(input logic [7:0] pre, input logic [3:0] ps);
        logic [3:0] code;
        logic [7:0] mask;
        code = (ps > MTM_PS_MAX) ? MTM_PS_MAX : ps;
        mask = 8'(9'(9'h001 << code) - 9'h001);
        return (pre & mask) == mask;
    endfunction

    logic       src_pulse;
    logic       tick;
    logic       run;
    logic       aw_ok;
    logic       w_ok;
    logic       do_wr;
    logic       do_rd;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic       ovf_evt;

    // Handshake outputs
    assign aw_ok = axi_req.awvalid && !s_r.aw_have && !s_r.bvalid;
    assign w_ok  = axi_req.wvalid && !s_r.w_have && !s_r.bvalid;
    assign do_rd = axi_req.arvalid && !s_r.rvalid;
    assign run   = !s_r.halt && !debug_halt;

    always_comb begin
        axi_rsp         = '0;
        axi_rsp.awready = aw_ok;
        axi_rsp.wready  = w_ok;
        axi_rsp.bvalid  = s_r.bvalid;
        axi_rsp.bresp   = s_r.bresp;
        axi_rsp.arready = do_rd;
        axi_rsp.rvalid  = s_r.rvalid;
        axi_rsp.rdata   = s_r.rdata;
        axi_rsp.rresp   = s_r.rresp;
    end

    // Mode and interrupt
    assign irq = s_r.ovf && s_r.ien;
    always_comb begin
        if (s_r.halt) begin
            mode = MTM_ST_STOPPED;
        end else if (s_r.modulo == MTM_ZERO8) begin
            mode = MTM_ST_FREE;
        end else begin
            mode = MTM_ST_MODULO;
        end
    end

    // Source pulse selection: bus source always pulses, others from synchronised edges
    always_comb begin
        case (s_r.src)
            MTM_SRC_BUS:  src_pulse = 1'b1;
            MTM_SRC_FIX:  src_pulse = s_r.fix_sync[1] && !s_r.fix_last;
            MTM_SRC_FALL: src_pulse = !s_r.pin_sync[1] && s_r.pin_last;
            MTM_SRC_RISE: src_pulse = s_r.pin_sync[1] && !s_r.pin_last;
            default:      src_pulse = 1'b1;
        endcase
    end

    assign tick    = run && src_pulse && tap_hit(s_r.pre, s_r.ps);
    assign ovf_evt = tick && (s_r.count == s_r.modulo) && (s_r.modulo != MTM_ZERO8)
                     || tick && (s_r.modulo == MTM_ZERO8) && (s_r.count == 8'hFF);
    assign do_wr   = (s_r.aw_have || aw_ok) && (s_r.w_have || w_ok) && !s_r.bvalid;
    assign wbyte   = s_r.w_have ? s_r.w_data[7:0] : axi_req.wdata[7:0];

    // Read mux
    always_comb begin
        rbyte = MTM_ZERO8;
        case (axi_req.araddr)
            MTM_ADDR_SC: begin
                rbyte[MTM_SC_OVF]  = s_r.ovf;
                rbyte[MTM_SC_IEN]  = s_r.ien;
                rbyte[MTM_SC_HALT] = s_r.halt;
            end
            MTM_ADDR_CLK: rbyte = {2'h0, s_r.src, s_r.ps};
            MTM_ADDR_CNT: rbyte = s_r.count;
            MTM_ADDR_MOD: rbyte = s_r.modulo;
            default:      rbyte = MTM_ZERO8;
        endcase
    end

    // Next state
    always_comb begin
        logic [3:0] wa;
        logic       lane0;
        wa    = s_r.aw_have ? s_r.aw_addr : axi_req.awaddr;
        lane0 = s_r.w_have ? s_r.w_lane0 : axi_req.wstrb[0];
        s_nxt = s_r;
        // Synchronisers and edge memory
        s_nxt.pin_sync = {s_r.pin_sync[0], ext_timer_clock_pin};
        s_nxt.pin_last = s_r.pin_sync[1];
        s_nxt.fix_sync = {s_r.fix_sync[0], fixed_freq_clock};
        s_nxt.fix_last = s_r.fix_sync[1];
        // Prescaler advances on each source pulse while running
        if (run && src_pulse) begin
            s_nxt.pre = s_r.pre + 8'h01;
        end
        // Counter
        if (tick) begin
            if (ovf_evt) begin
                s_nxt.count = MTM_ZERO8;
            end else begin
                s_nxt.count = s_r.count + 8'h01;
            end
        end
        // Write address and data capture
        if (aw_ok && !do_wr) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (w_ok && !do_wr) begin
            s_nxt.w_have  = 1'b1;
            s_nxt.w_data  = axi_req.wdata;
            s_nxt.w_lane0 = axi_req.wstrb[0];
        end
        if (axi_req.bready && s_r.bvalid) begin
            s_nxt.bvalid = 1'b0;
        end
        // Register write effects
        if (do_wr) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = (wa[1:0] == 2'h0 && wa <= MTM_ADDR_MOD) ? MTM_RESP_OK
                                                                   : MTM_RESP_SLVERR;
            if (lane0) begin
                case (wa)
                    MTM_ADDR_SC: begin
                        s_nxt.ien  = wbyte[MTM_SC_IEN];
                        s_nxt.halt = wbyte[MTM_SC_HALT];
                        if (!wbyte[MTM_SC_OVF] && s_r.armed) begin
                            s_nxt.ovf = 1'b0;
                        end
                        s_nxt.armed = 1'b0;
                        if (wbyte[MTM_SC_RST]) begin
                            s_nxt.count = MTM_ZERO8;
                            s_nxt.pre   = MTM_ZERO8;
                            s_nxt.ovf   = 1'b0;
                        end
                    end
                    MTM_ADDR_CLK: begin
                        s_nxt.src = wbyte[MTM_CLK_SRC_HI:MTM_CLK_SRC_LO];
                        s_nxt.ps  = wbyte[MTM_CLK_PS_HI:0];
                    end
                    MTM_ADDR_MOD: begin
                        s_nxt.modulo = wbyte;
                        s_nxt.count  = MTM_ZERO8;
                        s_nxt.pre    = MTM_ZERO8;
                        s_nxt.ovf    = 1'b0;
                        s_nxt.armed  = 1'b0;
                    end
                    default: begin
                        s_nxt.ien = s_r.ien; // Count register ignores writes
                    end
                endcase
            end
        end
        // Read channel
        if (axi_req.rready && s_r.rvalid) begin
            s_nxt.rvalid = 1'b0;
        end
        if (do_rd) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = {24'h000000, rbyte};
            s_nxt.rresp  = (axi_req.araddr[1:0] == 2'h0) ? MTM_RESP_OK : MTM_RESP_SLVERR;
            if (axi_req.araddr == MTM_ADDR_SC && s_r.ovf) begin
                s_nxt.armed = 1'b1;
            end
        end
        // New overflow sets the flag and cancels any pending clear
        if (ovf_evt) begin
            s_nxt.ovf   = 1'b1;
            s_nxt.armed = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r      <= '0;
            s_r.halt <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Overflow tick always wraps count and raises flag
    sequence s_wrap;
        ovf_evt ##1 (s_r.count == MTM_ZERO8 && s_r.ovf);
    endsequence

    a_wrap_flag: assert property (@(posedge ref_clk) disable iff (rst)
        ovf_evt |-> s_wrap)
        else $error("overflow did not wrap and flag");
    a_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (ovf_evt && s_r.ien && !do_wr) |=> irq)
        else $error("irq not raised on overflow");
    a_halt_freeze: assert property (@(posedge ref_clk) disable iff (rst)
        (s_r.halt && !do_wr) |=> $stable(s_r.count))
        else $error("count moved while halted");
    a_debug_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (debug_halt && !do_wr) |=> $stable(s_r.count))
        else $error("count moved in debug");
    a_mod_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (do_wr && lane0_w() && wa_w() == MTM_ADDR_MOD) |=> (s_r.count == MTM_ZERO8 && !s_r.ovf))
        else $error("modulo write did not clear");
    a_no_arm_keep: assert property (@(posedge ref_clk) disable iff (rst)
        (s_r.ovf && !s_r.armed && !(do_wr && lane0_w() && wa_w() == MTM_ADDR_SC && wbyte[MTM_SC_RST])
         && !(do_wr && lane0_w() && wa_w() == MTM_ADDR_MOD)) |=> s_r.ovf)
        else $error("flag cleared without arming read");
    a_ovf_set: assert property (@(posedge ref_clk) disable iff (rst)
        ovf_evt |=> s_r.ovf && !s_r.armed)
        else $error("overflow lost");
    a_step_one: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && !ovf_evt && !do_wr) |=> s_r.count == $past(s_r.count) + 8'h01)
        else $error("count did not step");
    a_rst_state: assert property (@(posedge ref_clk)
        rst |=> (s_r.halt && s_r.count == MTM_ZERO8 && s_r.ps == 4'h0 && s_r.src == MTM_SRC_BUS))
        else $error("bad reset state");

    // Two steps of a flag clear: arming status read, then clearing write
    sequence s_arm_read;
        do_rd && axi_req.araddr == MTM_ADDR_SC && s_r.ovf && !ovf_evt;
    endsequence
    sequence s_clear_write;
        s_r.armed && do_wr && lane0_w() && wa_w() == MTM_ADDR_SC && !wbyte[MTM_SC_OVF]
        && !ovf_evt;
    endsequence

    // Flag clearing steps
    a_arm_read: assert property (@(posedge ref_clk) disable iff (rst)
        s_arm_read |=> s_r.armed)
        else $error("status read did not arm the clear");
    a_arm_clear: assert property (@(posedge ref_clk) disable iff (rst)
        s_clear_write |=> !s_r.ovf)
        else $error("armed clear left the flag set");

    // Register side effects on the count, free-range wrap and write response
    a_reset_bit: assert property (@(posedge ref_clk) disable iff (rst)
        (do_wr && lane0_w() && wa_w() == MTM_ADDR_SC && wbyte[MTM_SC_RST] && !ovf_evt)
        |=> (s_r.count == MTM_ZERO8 && !s_r.ovf))
        else $error("counter reset bit did not clear");
    a_count_ro: assert property (@(posedge ref_clk) disable iff (rst)
        (do_wr && wa_w() == MTM_ADDR_CNT && !tick) |=> $stable(s_r.count))
        else $error("count register took a write");
    a_free_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        (tick && s_r.modulo == MTM_ZERO8 && s_r.count == ~MTM_ZERO8 && !do_wr)
        |=> (s_r.count == MTM_ZERO8 && s_r.ovf))
        else $error("free count did not wrap from full range");
    a_write_resp: assert property (@(posedge ref_clk) disable iff (rst)
        do_wr |=> s_r.bvalid)
        else $error("write response missing");

    // Helpers giving the effective write address and lane for assertions
    function automatic logic [3:0] wa_w();
        return s_r.aw_have ? s_r.aw_addr : axi_req.awaddr;
    endfunction
    function automatic logic lane0_w();
        return s_r.w_have ? s_r.w_lane0 : axi_req.wstrb[0];
    endfunction
endmodule // mtm_timer

// File: mtm_far_clk.sv
// Far-side model: drives the external timer pin and the fixed-frequency clock line.
module mtm_far_clk (
    input  wire logic        ref_clk, // Bus clock
    input  wire logic        go,      // Start a burst of edges
    input  wire logic [15:0] n_edges, // Level changes in the burst
    input  wire logic        use_fix, // Toggle fixed clock instead of pin
    output logic             busy,    // Burst in progress
    output logic             pin,     // External timer clock
    output logic             fix      // Fixed-frequency clock
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each level lasts four bus cycles, an eighth of the bus rate at most
    initial begin
        busy = 1'b0;
        pin = 1'b0;
        fix = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go) begin
                busy <= 1'b1;
                repeat (n_edges) begin
                    repeat (4) @(posedge ref_clk);
                    if (use_fix) fix <= ~fix;
                    else pin <= ~pin;
                end
                repeat (6) @(posedge ref_clk);
                busy <= 1'b0;
            end
        end
    end
endmodule // mtm_far_clk

// File: tb.sv
// Self-checking bench for the modulo timer against a behavioural model.
module tb;
    import mtm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    mtm_axi_req_s axi_req = '0;
    mtm_axi_rsp_s axi_rsp;
    logic         pin, fix, busy, irq;
    logic         go = 1'b0, use_fix = 1'b0, debug_halt = 1'b0;
    logic [15:0]  n_edges = 16'h0000;
    mtm_mode_e    mode;
    logic [31:0]  rd_data;
    logic [1:0]   resp;
    int mismatches = 0, checked = 0;
    int m_cnt = 0, m_mod = 0, m_pre = 0, m_src = 0, m_ps = 0, m_halt = 1;
    int m_ovf = 0, m_arm = 0, m_ien = 0, m_pin = 0, m_fix = 0;

    // Bus clock, 25 ns period
    always #12.5 ref_clk = ~ref_clk;

    mtm_timer mtm_timer_i (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .ext_timer_clock_pin(pin), .fixed_freq_clock(fix), .debug_halt(debug_halt),
        .irq(irq), .mode(mode));
    mtm_far_clk mtm_far_clk_i (.ref_clk(ref_clk), .go(go), .n_edges(n_edges),
        .use_fix(use_fix), .busy(busy), .pin(pin), .fix(fix));

    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: bus value %0h, want %0h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: output %0h, want %0h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] m_mode();
        return m_halt ? MTM_ST_STOPPED : (m_mod == 0 ? MTM_ST_FREE : MTM_ST_MODULO);
    endfunction

    // One source pulse into the model prescaler
    task automatic tick();
        m_pre++;
        if (m_pre >= (1 << (m_ps > 8 ? 8 : m_ps))) begin
            m_pre = 0;
            if (m_cnt == (m_mod == 0 ? 255 : m_mod)) begin
                m_cnt = 0;
                m_ovf = 1;
                m_arm = 0;
            end
            else m_cnt++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bit ah, wh, bh;
        bh = 0;
        @(posedge ref_clk);
        axi_req.awaddr <= a;
        axi_req.wdata <= {24'h000000, d};
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        while (!bh) begin
            @(negedge ref_clk);
            ah = axi_req.awvalid && axi_rsp.awready;
            wh = axi_req.wvalid && axi_rsp.wready;
            bh = axi_rsp.bvalid;
            resp = axi_rsp.bresp;
            @(posedge ref_clk);
            if (ah) axi_req.awvalid <= 1'b0;
            if (wh) axi_req.wvalid <= 1'b0;
        end
        axi_req.bready <= 1'b0;
        chk_out({1'b0, bh}, 2'h1);
        chk_out(resp, a[1:0] != 0 ? MTM_RESP_SLVERR : MTM_RESP_OK);
        case (a)
            MTM_ADDR_SC: begin
                if (d[5]) begin
                    m_cnt = 0;
                    m_pre = 0;
                    m_ovf = 0;
                end
                if (!d[7] && m_arm) m_ovf = 0;
                m_arm = 0;
                m_ien = d[6];
                m_halt = d[4];
            end
            MTM_ADDR_CLK: begin
                m_src = d[5:4];
                m_ps = d[3:0];
            end
            MTM_ADDR_MOD: begin
                m_mod = d;
                m_cnt = 0;
                m_pre = 0;
                m_ovf = 0;
                m_arm = 0;
            end
            default: ;
        endcase
    endtask

    task automatic rd(input logic [3:0] a, input bit cmp);
        bit ah, rh;
        logic [31:0] exp;
        rh = 0;
        @(posedge ref_clk);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        while (!rh) begin
            @(negedge ref_clk);
            ah = axi_req.arvalid && axi_rsp.arready;
            rh = axi_rsp.rvalid;
            rd_data = axi_rsp.rdata;
            resp = axi_rsp.rresp;
            @(posedge ref_clk);
            if (ah) axi_req.arvalid <= 1'b0;
        end
        axi_req.rready <= 1'b0;
        case (a)
            MTM_ADDR_SC: exp = {24'h0, m_ovf[0], m_ien[0], 1'b0, m_halt[0], 4'h0};
            MTM_ADDR_CLK: exp = {26'h0, m_src[1:0], m_ps[3:0]};
            MTM_ADDR_CNT: exp = m_cnt;
            MTM_ADDR_MOD: exp = m_mod;
            default: exp = 32'h00000000;
        endcase
        chk_out({1'b0, rh}, 2'h1);
        chk_out(resp, a[1:0] != 0 ? MTM_RESP_SLVERR : MTM_RESP_OK);
        if (cmp) chk_reg(rd_data, exp);
        if (a == MTM_ADDR_SC && m_ovf) m_arm = 1;
    endtask

    // Burst of level changes from the far side, mirrored in the model
    task automatic pulse(input int n, input bit on_fix);
        int k;
        k = 0;
        @(posedge ref_clk);
        n_edges <= n[15:0];
        use_fix <= on_fix;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(negedge ref_clk);
        while (busy !== 1'b0 && k < 20000) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 20000) begin
            mismatches++;
            $display("unexpected at %0t: far side stayed busy", $time);
        end
        for (int i = 0; i < n; i++) begin
            if (on_fix) m_fix ^= 1;
            else m_pin ^= 1;
            if (!m_halt && !debug_halt && ((on_fix && m_src == 1 && m_fix)
                || (!on_fix && ((m_src == 3 && m_pin) || (m_src == 2 && !m_pin)))))
                tick();
        end
    endtask

    // Watchdog
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end

    // Main sequence
    initial begin
        void'($urandom(99196));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4) rd(a[3:0], 1);
        chk_out(mode, m_mode());
        wr(MTM_ADDR_SC, 8'h00);
        chk_out(mode, m_mode());
        for (int s = 1; s < 4; s++) begin
            for (int p = 0; p < 10; p++) begin
                wr(MTM_ADDR_CLK, {2'b00, s[1:0], p[3:0]});
                wr(MTM_ADDR_MOD, 8'($urandom_range(1, 3)));
                pulse(2 * $urandom_range(1, 3) << (p > 8 ? 8 : p), s == 1);
                rd(MTM_ADDR_CNT, 1);
                rd(MTM_ADDR_SC, 1);
            end
        end
        chk_out(mode, m_mode());
        wr(MTM_ADDR_MOD, 8'h00);
        wr(MTM_ADDR_CLK, 8'h32);
        pulse(16, 0);
        wr(MTM_ADDR_CLK, 8'h21);
        pulse(8, 0);
        rd(MTM_ADDR_CNT, 1);
        wr(MTM_ADDR_CNT, 8'h5A);
        rd(MTM_ADDR_CNT, 1);
        wr(MTM_ADDR_SC, 8'h10);
        pulse(6, 0);
        rd(MTM_ADDR_CNT, 1);
        rd(MTM_ADDR_SC, 1);
        chk_out(mode, m_mode());
        wr(MTM_ADDR_SC, 8'h00);
        @(posedge ref_clk) debug_halt <= 1'b1;
        pulse(6, 0);
        rd(MTM_ADDR_CNT, 1);
        @(posedge ref_clk) debug_halt <= 1'b0;
        wr(MTM_ADDR_CLK, 8'h30);
        pulse(2 * (256 - m_cnt), 0);
        rd(MTM_ADDR_CNT, 1);
        rd(MTM_ADDR_SC, 1);
        pulse(512, 0);
        wr(MTM_ADDR_SC, 8'h00);
        rd(MTM_ADDR_SC, 1);
        wr(MTM_ADDR_SC, 8'h00);
        rd(MTM_ADDR_SC, 1);
        wr(MTM_ADDR_SC, 8'h40);
        chk_out({1'b0, irq}, 2'h0);
        wr(MTM_ADDR_MOD, 8'h02);
        chk_out(mode, m_mode());
        pulse(8, 0);
        chk_out({1'b0, irq}, {1'b0, m_ovf[0] & m_ien[0]});
        wr(MTM_ADDR_SC, 8'hC0);
        rd(MTM_ADDR_SC, 1);
        wr(MTM_ADDR_SC, 8'h60);
        rd(MTM_ADDR_SC, 1);
        rd(MTM_ADDR_CNT, 1);
        chk_out({1'b0, irq}, 2'h0);
        wr(MTM_ADDR_MOD, 8'h00);
        wr(MTM_ADDR_CLK, 8'h00);
        wr(MTM_ADDR_SC, 8'h10);
        rd(MTM_ADDR_CNT, 0);
        chk_out({1'b0, rd_data != 0}, 2'h1);
        wr(MTM_ADDR_SC, 8'h30);
        rd(MTM_ADDR_CNT, 1);
        wr(4'h2, 8'hFF);
        rd(MTM_ADDR_SC, 1);
        rd(4'h6, 1);
        summarize();
    end
endmodule // tb
